// [src/pts_sequencer.sv]
// Pulse train sequencer: five preset down-counters on a 1 MHz tick,
// biphasic follow-on stage and an AXI4-Lite register slave.
// Assumes pins arrive asynchronously and the bus runs on aclk.
//
// Behaviour
// - each parameter has its own preset down-counter
// - counter output high until zero or reset
// - start launches period and lead counters
// - lead expiry triggers interval, count, width counters
// - interval expiry retriggers itself and width counter
// - pulse count decrements on width completions, inhibits
// - period expiry emits done in repeat mode, resets all counters
// - repeat mode restarts, one-shot mode stops
// - done at train end single, period continuous
// - extra-pulse input fires the width counter
// - extra pulse during train counts as train pulse
// - width counter output is the pulse output
// - second equal-width phase starts 10 us later
// - bipolar selects positive then negative reference
// - asymmetric mode times second phase separately
// - presets decode as three digits times ten-power
// - entry on reloads each cycle with lag
// - button starts when idle, halts when running
// - external rising edge starts, stop optional
`timescale 1ns/10ps
`default_nettype none

module pts_sequencer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pts_pkg::pts_axi_req_t axi_req,
  output pts_pkg::pts_axi_rsp_t axi_rsp,
  input wire pts_pkg::pts_pins_in_t pins_in,
  output pts_pkg::pts_pins_out_t pins_out
);

  pts_pkg::pts_state_t st;
  pts_pkg::pts_state_t next_st;
  logic [5:0][39:0] dec;

  // three significant digits times ten-power, nine selects minutes
  function automatic logic [39:0] pts_decode(input logic [15:0] s);
    logic [39:0] sig;
    logic [79:0] prod;
    begin
      sig = 40'(s[15:12]) * 40'h64 + 40'(s[11:8]) * 40'hA + 40'(s[7:4]);
      if (s[3:0] >= 4'h9)
        prod = sig * pts_pkg::US_PER_MIN;
      else
        prod = sig * pts_pkg::POW10[s[3:0]];
      pts_decode = prod[39:0];
    end
  endfunction

  // one decoder per switch set feeding its own counter
  for (genvar i = 0; i < pts_pkg::NSW; i++)
  begin : g_dec
    assign dec[i] = pts_decode(st.sw[i]);
  end

  // Bus handshakes are combinational, data and responses registered
  assign axi_rsp.awready = !st.aw_got && !st.bvalid;
  assign axi_rsp.wready = !st.w_got && !st.bvalid;
  assign axi_rsp.bvalid = st.bvalid;
  assign axi_rsp.bresp = st.bresp;
  assign axi_rsp.arready = !st.rvalid;
  assign axi_rsp.rvalid = st.rvalid;
  assign axi_rsp.rdata = st.rdata;
  assign axi_rsp.rresp = st.rresp;

  // the width counter's latch is the logic-level pulse
  assign pins_out.pulse_out = st.width_act;
  assign pins_out.done_out = st.done_out;
  assign pins_out.sync_out = st.period_act;
  assign pins_out.lead_out = st.lead_act;
  // positive reference for phase one, negative for phase two
  assign pins_out.ref_pos_sel = st.width_act;
  assign pins_out.ref_neg_sel = st.phase == pts_pkg::PTS_PH_SECOND;
  // the stimulus gate is built only from the width timing
  assign pins_out.stim_gate = st.width_act ||
    st.phase == pts_pkg::PTS_PH_SECOND;

  // Next-state logic: bus slave first, then the counter chain
  always_comb
  begin
    logic tick;
    logic btn_rise;
    logic ext_rise;
    logic add_rise;
    logic sw_start;
    logic go;
    logic halt;
    logic launch;
    logic fire;
    logic period_done;
    logic lead_done;
    logic ivl_done;
    logic width_done;
    logic train_end;
    logic done_evt;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [2:0] wi;
    logic [2:0] ri;
    tick = 1'b0;
    btn_rise = 1'b0;
    ext_rise = 1'b0;
    add_rise = 1'b0;
    sw_start = 1'b0;
    go = 1'b0;
    halt = 1'b0;
    launch = 1'b0;
    fire = 1'b0;
    period_done = 1'b0;
    lead_done = 1'b0;
    ivl_done = 1'b0;
    width_done = 1'b0;
    train_end = 1'b0;
    done_evt = 1'b0;
    wa = st.aw_addr;
    ra = axi_req.araddr;
    wi = 3'((wa - pts_pkg::OFF_SW_BASE) >> 2);
    ri = 3'((ra - pts_pkg::OFF_SW_BASE) >> 2);
    next_st = st;

    // 1 MHz enable from the 20 MHz clock
    tick = st.div == pts_pkg::TICK_DIV - 5'h1;
    next_st.div = tick ? 5'h0 : st.div + 5'h1;

    // Two-flop synchronisers, third stage only for edge detection
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    btn_rise = st.s2.start_button && !st.s3.start_button;
    ext_rise = st.s2.ext_start && !st.s3.ext_start;
    add_rise = st.s2.add_pulse && !st.s3.add_pulse;

    // Write address and data are taken independently, in either order
    if (axi_req.awvalid && !st.aw_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st.w_got && !st.bvalid)
    begin
      next_st.w_got = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end
    // The register write happens one cycle after both halves are held
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = pts_pkg::RESP_OKAY;
      if (wa == pts_pkg::OFF_CTRL)
      begin
        if (st.w_strb[0])
        begin
          next_st.ctrl = st.w_data[pts_pkg::CTRL_W-1:0];
          if (st.w_data[pts_pkg::CB_ENTER])
            next_st.hold = dec;
          sw_start = st.w_data[pts_pkg::CB_START];
        end
      end
      else if (wa >= pts_pkg::OFF_SW_BASE && wa < pts_pkg::OFF_SW_END &&
               wa[1:0] == 2'h0)
      begin
        if (st.w_strb[0])
          next_st.sw[wi][7:0] = st.w_data[7:0];
        if (st.w_strb[1])
          next_st.sw[wi][15:8] = st.w_data[15:8];
      end
      else if (wa != pts_pkg::OFF_STATUS)
        next_st.bresp = pts_pkg::RESP_SLVERR;
    end
    if (st.bvalid && axi_req.bready)
      next_st.bvalid = 1'b0;

    // Reads answer one cycle after the address is taken
    if (axi_req.arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = pts_pkg::RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (ra == pts_pkg::OFF_CTRL)
        next_st.rdata = 32'(st.ctrl);
      else if (ra == pts_pkg::OFF_STATUS)
        next_st.rdata = {26'h000_0000, st.done_out, st.width_act,
          st.train_act, st.loading, st.phase != pts_pkg::PTS_PH_IDLE,
          st.running};
      else if (ra >= pts_pkg::OFF_SW_BASE && ra < pts_pkg::OFF_SW_END &&
               ra[1:0] == 2'h0)
        next_st.rdata = {16'h0000, st.sw[ri]};
      else if (ra == pts_pkg::OFF_LEFT)
        next_st.rdata = st.num_left[31:0];
      else
        next_st.rresp = pts_pkg::RESP_SLVERR;
    end
    else if (st.rvalid && axi_req.rready)
      next_st.rvalid = 1'b0;

    // the button halts a running cycle at once
    // external edge stops only when the stop option is set
    halt = st.running && (btn_rise ||
      (ext_rise && st.ctrl[pts_pkg::CB_EXT_STOP]));
    go = !st.running && (btn_rise || ext_rise || sw_start);

    // latches stay high until count hits zero or a reset
    // each expiry is a single event on the tick edge
    period_done = st.period_act && tick && st.period_cnt <= 40'h1;
    lead_done = st.lead_act && tick && st.lead_cnt <= 40'h1;
    ivl_done = st.ivl_act && tick && st.ivl_cnt <= 40'h1;
    width_done = st.width_act && tick && st.width_cnt <= 40'h1;

    // active counters step down once per microsecond
    if (tick)
    begin
      if (st.period_act)
        next_st.period_cnt = st.period_cnt - 40'h1;
      if (st.lead_act)
        next_st.lead_cnt = st.lead_cnt - 40'h1;
      if (st.ivl_act)
        next_st.ivl_cnt = st.ivl_cnt - 40'h1;
      if (st.width_act)
        next_st.width_cnt = st.width_cnt - 40'h1;
    end

    // with entry on, reload and wait the lag before launching
    if (st.loading && tick)
    begin
      if (st.lag_cnt <= 4'h1)
      begin
        next_st.loading = 1'b0;
        launch = 1'b1;
      end
      else
        next_st.lag_cnt = st.lag_cnt - 4'h1;
    end

    if (lead_done)
    begin
      next_st.lead_act = 1'b0;
      next_st.train_act = 1'b1;
      next_st.num_left = st.hold[pts_pkg::IX_COUNT] == 40'h0 ? 40'h1 :
        st.hold[pts_pkg::IX_COUNT];
      next_st.ivl_act = 1'b1;
      next_st.ivl_cnt = st.hold[pts_pkg::IX_IVL];
      fire = 1'b1;
    end

    // interval expiry retriggers while the train is open
    if (ivl_done)
    begin
      if (st.train_act)
      begin
        next_st.ivl_cnt = st.hold[pts_pkg::IX_IVL];
        fire = 1'b1;
      end
      else
        next_st.ivl_act = 1'b0;
    end

    // completions count down the train, then inhibit retriggers
    // extra pulses inside a train are counted the same way
    if (width_done)
    begin
      next_st.width_act = 1'b0;
      if (st.train_act)
      begin
        next_st.num_left = st.num_left - 40'h1;
        if (st.num_left <= 40'h1)
        begin
          next_st.train_act = 1'b0;
          next_st.ivl_act = 1'b0;
          train_end = 1'b1;
        end
      end
    end

    // the extra-pulse edge fires the width counter at any time
    if (add_rise)
      fire = 1'b1;
    if (fire)
    begin
      next_st.width_act = 1'b1;
      next_st.width_cnt = st.hold[pts_pkg::IX_WIDTH];
    end

    // Biphasic follow-on stage
    case (st.phase)
      pts_pkg::PTS_PH_IDLE:
      begin
        // second phase follows a first phase only if it ends while the stage is idle
        if (width_done && st.ctrl[pts_pkg::CB_BIPOLAR])
        begin
          next_st.phase = pts_pkg::PTS_PH_GAP;
          next_st.ph_cnt = 40'(pts_pkg::GAP_TICKS);
        end
      end
      pts_pkg::PTS_PH_GAP:
      begin
        if (tick)
        begin
          if (st.ph_cnt <= 40'h1)
          begin
            next_st.phase = pts_pkg::PTS_PH_SECOND;
            // asymmetric mode uses the second width set
            next_st.ph_cnt = st.ctrl[pts_pkg::CB_ASYM] ?
              st.hold[pts_pkg::IX_WIDTH2] : st.hold[pts_pkg::IX_WIDTH];
          end
          else
            next_st.ph_cnt = st.ph_cnt - 40'h1;
        end
      end
      pts_pkg::PTS_PH_SECOND:
      begin
        if (tick)
        begin
          if (st.ph_cnt <= 40'h1)
            next_st.phase = pts_pkg::PTS_PH_IDLE;
          else
            next_st.ph_cnt = st.ph_cnt - 40'h1;
        end
      end
      default:
      begin
        next_st.phase = pts_pkg::PTS_PH_IDLE;
      end
    endcase

    // period expiry clears all five counters
    if (period_done)
    begin
      next_st.period_act = 1'b0;
      next_st.lead_act = 1'b0;
      next_st.ivl_act = 1'b0;
      next_st.train_act = 1'b0;
      next_st.width_act = 1'b0;
      // only repeat mode starts the next cycle
      if (st.ctrl[pts_pkg::CB_REPEAT])
        go = 1'b1;
      else
        next_st.running = 1'b0;
    end

    // a start loads period and lead together
    // entry on copies the switches and adds the lag
    if (go)
    begin
      next_st.running = 1'b1;
      if (st.ctrl[pts_pkg::CB_ENTRY_ON])
      begin
        next_st.hold = dec;
        next_st.loading = 1'b1;
        next_st.lag_cnt = pts_pkg::LAG_TICKS;
      end
      else
        launch = 1'b1;
    end
    if (launch)
    begin
      next_st.period_act = 1'b1;
      next_st.period_cnt = st.hold[pts_pkg::IX_PERIOD];
      next_st.lead_act = 1'b1;
      next_st.lead_cnt = st.hold[pts_pkg::IX_LEAD];
    end

    // done follows the train in one-shot, the period in repeat
    done_evt = st.ctrl[pts_pkg::CB_REPEAT] ? period_done : train_end;
    // done is stretched to exactly one microsecond
    if (done_evt)
      next_st.done_out = 1'b1;
    else if (tick)
      next_st.done_out = 1'b0;

    // halt overrides everything in the counter chain
    if (halt)
    begin
      next_st.running = 1'b0;
      next_st.loading = 1'b0;
      next_st.period_act = 1'b0;
      next_st.lead_act = 1'b0;
      next_st.ivl_act = 1'b0;
      next_st.train_act = 1'b0;
      next_st.width_act = 1'b0;
      next_st.phase = pts_pkg::PTS_PH_IDLE;
      next_st.done_out = 1'b0;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.ctrl <= pts_pkg::CTRL_RST;
      st.sw <= {pts_pkg::NSW{pts_pkg::SW_RST}};
      st.hold <= {pts_pkg::NSW{pts_pkg::HOLD_RST}};
      st.phase <= pts_pkg::PTS_PH_IDLE;
    end
    else
      st <= next_st;
  end

endmodule

`default_nettype wire

// [inc/pts_pkg.sv]
// Package for the pulse train sequencer: register map, control fields,
// reset values, tick timing, state and port carrier types.
// Assumes a 20 MHz aclk and an AXI4-Lite master with an 8-bit address.
package pts_pkg;

  // Clock and 1 MHz counting tick
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_HZ = 1_000_000;
  localparam logic [4:0] TICK_DIV = 5'(CLK_HZ / TICK_HZ);
  // Parameter load lag and second-phase gap, in microseconds
  localparam int unsigned LAG_US = 10;
  localparam int unsigned GAP_US = 10;
  localparam logic [3:0] LAG_TICKS = 4'(LAG_US * TICK_HZ / 1_000_000);
  localparam logic [3:0] GAP_TICKS = 4'(GAP_US * TICK_HZ / 1_000_000);

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SW_BASE = 8'h08;
  localparam logic [7:0] OFF_SW_END = 8'h20;
  localparam logic [7:0] OFF_LEFT = 8'h20;

  // Switch set indices
  localparam int NSW = 6;
  localparam int IX_PERIOD = 0;
  localparam int IX_LEAD = 1;
  localparam int IX_IVL = 2;
  localparam int IX_COUNT = 3;
  localparam int IX_WIDTH = 4;
  localparam int IX_WIDTH2 = 5;

  // Control register fields
  localparam int CB_REPEAT = 0;
  localparam int CB_ENTRY_ON = 1;
  localparam int CB_BIPOLAR = 2;
  localparam int CB_ASYM = 3;
  localparam int CB_EXT_STOP = 4;
  localparam int CB_ENTER = 5;
  localparam int CB_START = 6;
  localparam int CTRL_W = 5;

  // Reset values: one-shot sequence, entry off, every switch set at 1 us
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] SW_RST = 16'h0010;
  localparam logic [39:0] HOLD_RST = 40'h00_0000_0001;

  // Time base multipliers
  localparam logic [39:0] US_PER_MIN = 40'h00_0393_8700;
  localparam logic [8:0][39:0] POW10 = {
    40'h00_05F5_E100, 40'h00_0098_9680, 40'h00_000F_4240,
    40'h00_0001_86A0, 40'h00_0000_2710, 40'h00_0000_03E8,
    40'h00_0000_0064, 40'h00_0000_000A, 40'h00_0000_0001};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PTS_PH_IDLE, PTS_PH_GAP, PTS_PH_SECOND}
    pts_phase_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pts_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pts_axi_rsp_t;

  typedef struct packed {
    logic start_button;
    logic ext_start;
    logic add_pulse;
  } pts_pins_in_t;

  typedef struct packed {
    logic pulse_out;
    logic done_out;
    logic sync_out;
    logic lead_out;
    logic ref_pos_sel;
    logic ref_neg_sel;
    logic stim_gate;
  } pts_pins_out_t;

  typedef struct packed {
    logic [4:0] div;
    pts_pins_in_t s1;
    pts_pins_in_t s2;
    pts_pins_in_t s3;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] ctrl;
    logic [5:0][15:0] sw;
    logic [5:0][39:0] hold;
    logic running;
    logic loading;
    logic [3:0] lag_cnt;
    logic period_act;
    logic [39:0] period_cnt;
    logic lead_act;
    logic [39:0] lead_cnt;
    logic ivl_act;
    logic [39:0] ivl_cnt;
    logic train_act;
    logic [39:0] num_left;
    logic width_act;
    logic [39:0] width_cnt;
    pts_phase_t phase;
    logic [39:0] ph_cnt;
    logic done_out;
  } pts_state_t;

endpackage

// [verif/pts_seq_props.sv]
// Checker for the pulse train sequencer, seeing only its top ports.
// Assumes a 20 MHz aclk and a synchronous active-low aresetn.
`timescale 1ns/10ps
`default_nettype none
module pts_seq_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pts_pkg::pts_axi_req_t axi_req,
  input wire pts_pkg::pts_axi_rsp_t axi_rsp,
  input wire pts_pkg::pts_pins_in_t pins_in,
  input wire pts_pkg::pts_pins_out_t pins_out
);
  logic [5:0] done_len;
  logic [9:0] low_len;

  // Run lengths; the low count saturates so long idles stay harmless
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_len <= 6'h00;
      low_len <= 10'h000;
    end
    else
    begin
      done_len <= pins_out.done_out ? done_len + 6'h01 : 6'h00;
      low_len <= pins_out.pulse_out ? 10'h000 : low_len + {9'h000, ~&low_len};
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_both;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_ar_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence s_halt_press;
    $rose(pins_in.start_button) && pins_out.sync_out;
  endsequence
  sequence s_ext_idle;
    $rose(pins_in.ext_start) && !pins_out.sync_out;
  endsequence

  a_bvalid_hold:
    assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write response dropped early");
  a_rvalid_hold:
    assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  a_write_answer:
    assert property (s_wr_both |=> ##1 axi_rsp.bvalid)
    else $error("write response late");
  a_read_answer:
    assert property (s_ar_taken |=> axi_rsp.rvalid)
    else $error("read response late");
  a_write_refuse:
    assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while response pending");
  a_read_refuse:
    assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while response pending");
  a_done_width:
    assert property ($fell(pins_out.done_out) |-> done_len == 6'h14)
    else $error("done pulse not one microsecond");
  a_second_gap:
    assert property ($rose(pins_out.ref_neg_sel)
      |-> low_len >= 10'h0BE && low_len <= 10'h0D2)
    else $error("second phase gap wrong");
  a_phase_excl:
    assert property (pins_out.ref_neg_sel |-> !pins_out.ref_pos_sel)
    else $error("both references selected");
  a_button_halt:
    assert property (s_halt_press |-> ##[2:6] !pins_out.sync_out)
    else $error("button did not halt the cycle");
  a_ext_launch:
    assert property (s_ext_idle |-> ##[2:6] pins_out.sync_out)
    else $error("external start did not launch");
  a_lead_launch:
    assert property ($rose(pins_out.sync_out) |-> pins_out.lead_out)
    else $error("lead counter not launched with period");
  a_gate_source:
    assert property (pins_out.stim_gate ==
      (pins_out.pulse_out || pins_out.ref_neg_sel))
    else $error("stimulus gate not from the pulse timing");
endmodule

bind pts_sequencer pts_seq_props u_props (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .pins_in(pins_in),
  .pins_out(pins_out));
`default_nettype wire

// [verif/pts_panel_model.sv]
// Front-panel stand-in: push button, trigger jacks and a paired unit.
// Assumes the bench raises a fire bit for one aclk per press.
`timescale 1ns/10ps
`default_nettype none
module pts_panel_model
(
  input wire logic aclk,
  input wire logic [2:0] fire,
  input wire logic pair_on,
  input wire logic done_in,
  output pts_pkg::pts_pins_in_t pins
);
  logic [2:0][2:0] hold = '0;
  logic [9:0] pair_cnt = 10'h000;
  logic done_q = 1'b0;

  // Presses last four clocks so the synchronisers surely see them
  always @(posedge aclk)
  begin
    for (int i = 0; i < 3; i++)
      hold[i] <= fire[i] ? 3'h4 : hold[i] - {2'h0, |hold[i]};
    done_q <= done_in;
    pair_cnt <= (pair_on && done_q && !done_in) ? 10'h2BC :
      pair_cnt - {9'h000, |pair_cnt};
  end

  // Released jacks rest low, as an idle TTL source would leave them
  assign pins.add_pulse = |hold[0];
  assign pins.ext_start = |hold[1] || (pair_cnt != 10'h000 &&
    pair_cnt < 10'h005);
  assign pins.start_button = |hold[2];
endmodule
`default_nettype wire

// [verif/test_pulse_train_sequencer.sv]
// Self-checking bench for the pulse train sequencer.
// Assumes the panel model drives the pins and the checker is bound.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_pulse_train_sequencer;
  logic aclk;
  logic aresetn;
  pts_pkg::pts_axi_req_t axi_req;
  pts_pkg::pts_axi_rsp_t axi_rsp;
  pts_pkg::pts_pins_in_t pins_in;
  pts_pkg::pts_pins_out_t pins_out;
  logic [2:0] fire;
  logic pair_on;
  logic [31:0] rd;
  logic [1:0] rs;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0, t_first, t_done, pw, nw, sy, n_pulse, n_done, n;
  int pw_run = 0;
  int nw_run = 0;
  int sy_run = 0;
  int dn_run = 0;
  // Period, lead, interval 1x10^1, count, width, second width
  localparam logic [5:0][15:0] SW = {16'h0040, 16'h0020, 16'h0030,
    16'h0011, 16'h0200, 16'h0600};

  pts_sequencer dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .pins_in(pins_in), .pins_out(pins_out));
  pts_panel_model panel (.aclk(aclk), .fire(fire), .pair_on(pair_on),
    .done_in(pins_out.done_out), .pins(pins_in));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Output run lengths and event times, in aclk cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (pins_out.pulse_out && pw_run == 0)
    begin
      n_pulse++;
      if (n_pulse == 1)
        t_first = cyc;
    end
    if (pins_out.done_out && dn_run == 0)
    begin
      n_done++;
      t_done = cyc;
    end
    if (!pins_out.pulse_out && pw_run > 0)
      pw = pw_run;
    if (!pins_out.ref_neg_sel && nw_run > 0)
      nw = nw_run;
    if (!pins_out.sync_out && sy_run > 0)
      sy = sy_run;
    pw_run = pins_out.pulse_out ? pw_run + 1 : 0;
    nw_run = pins_out.ref_neg_sel ? nw_run + 1 : 0;
    sy_run = pins_out.sync_out ? sy_run + 1 : 0;
    dn_run = pins_out.done_out ? dn_run + 1 : 0;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tmo();
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    summarize();
  endtask

  task automatic clear();
    n_pulse = 0;
    n_done = 0;
    pw = 0;
    nw = 0;
    sy = 0;
    t_first = 0;
    t_done = 0;
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    int k;
    k = 0;
    b_ok = 1'b0;
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    while (!b_ok)
    begin
      @(negedge aclk);
      aw_ok = axi_req.awvalid && axi_rsp.awready;
      w_ok = axi_req.wvalid && axi_rsp.wready;
      b_ok = axi_rsp.bvalid === 1'b1;
      rs = axi_rsp.bresp;
      @(posedge aclk);
      if (aw_ok)
        axi_req.awvalid <= 1'b0;
      if (w_ok)
        axi_req.wvalid <= 1'b0;
      if (b_ok)
        axi_req.bready <= 1'b0;
      if (++k > 200)
        tmo();
    end
  endtask

  // Read: rready held from the start until rvalid is seen
  task automatic rd_reg(input logic [7:0] a);
    logic ar_ok, r_ok;
    int k;
    k = 0;
    r_ok = 1'b0;
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    while (!r_ok)
    begin
      @(negedge aclk);
      ar_ok = axi_req.arvalid && axi_rsp.arready;
      r_ok = axi_rsp.rvalid === 1'b1;
      rd = axi_rsp.rdata;
      rs = axi_rsp.rresp;
      @(posedge aclk);
      if (ar_ok)
        axi_req.arvalid <= 1'b0;
      if (r_ok)
        axi_req.rready <= 1'b0;
      if (++k > 200)
        tmo();
    end
  endtask

  // Set the mode first so the start sees it, then start
  task automatic go(input logic [4:0] m);
    wr(pts_pkg::OFF_CTRL, 32'(m));
    clear();
    wr(pts_pkg::OFF_CTRL, 32'(m) | (32'h1 << pts_pkg::CB_START));
    t0 = cyc;
  endtask

  task automatic press(input logic [2:0] f);
    fire <= f;
    @(posedge aclk);
    fire <= 3'h0;
  endtask

  // Wait for the cycle to start and end, then let phase two finish
  task automatic wait_run();
    int k;
    k = 0;
    while (pins_out.sync_out !== 1'b1 && k++ < 1000)
      @(posedge aclk);
    if (k >= 1000)
      tmo();
    while (pins_out.sync_out !== 1'b0 && k++ < 6000)
      @(posedge aclk);
    if (k >= 6000)
      tmo();
    repeat (300) @(posedge aclk);
  endtask

  initial
  begin
    repeat (100000) @(posedge aclk);
    tmo();
  end

  initial
  begin
    aresetn = 1'b0;
    axi_req = '0;
    fire = 3'h0;
    pair_on = 1'b0;
    clear();
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset contents, unmapped and read-only places
    rd_reg(pts_pkg::OFF_CTRL);
    `CHK(rd, 32'h0000_0000)
    rd_reg(pts_pkg::OFF_SW_BASE);
    `CHK(rd[15:0], pts_pkg::SW_RST)
    rd_reg(8'h24);
    `CHK(rs, pts_pkg::RESP_SLVERR)
    wr(8'h24, 32'hFFFF_FFFF);
    `CHK(rs, pts_pkg::RESP_SLVERR)
    wr(pts_pkg::OFF_STATUS, 32'h0000_003F);
    `CHK(rs, pts_pkg::RESP_OKAY)
    rd_reg(pts_pkg::OFF_STATUS);
    `CHK(rd, 32'h0000_0000)
    // Program all switch sets and enter them once
    for (int i = 0; i < pts_pkg::NSW; i++)
      wr(pts_pkg::OFF_SW_BASE + 8'(4 * i), 32'(SW[i]));
    rd_reg(pts_pkg::OFF_SW_BASE + 8'h08);
    `CHK(rd[15:0], SW[2])
    wr(pts_pkg::OFF_CTRL, 32'h1 << pts_pkg::CB_ENTER);
    rd_reg(pts_pkg::OFF_CTRL);
    `CHK(rd, 32'h0000_0000)
    // One-shot train of three
    go(5'h00);
    wait_run();
    `CHK(n_pulse, 3)
    `CHK(pw inside {[38:42]}, 1'b1)
    `CHK((t_first - t0) inside {[370:410]}, 1'b1)
    `CHK((t_done - t0) inside {[810:850]}, 1'b1)
    `CHK(sy inside {[1175:1205]}, 1'b1)
    `CHK(n_done, 1)
    // Extra pulse between the first and second train pulses
    go(5'h00);
    n = 0;
    while (pw == 0 && n++ < 2000)
      @(posedge aclk);
    if (n > 2000)
      tmo();
    press(3'h1);
    wait_run();
    `CHK(n_pulse, 3)
    `CHK(pw inside {[38:42]}, 1'b1)
    // Extra pulse while idle
    clear();
    press(3'h1);
    repeat (100) @(posedge aclk);
    `CHK(n_pulse, 1)
    `CHK(n_done, 0)
    // Single-pulse trains so phase two never meets the next pulse
    wr(pts_pkg::OFF_SW_BASE + 8'h0C, 32'h0000_0010);
    wr(pts_pkg::OFF_CTRL, 32'h24);
    clear();
    press(3'h2);
    wait_run();
    `CHK(nw inside {[38:42]}, 1'b1)
    go(5'h0C);
    wait_run();
    `CHK(nw inside {[78:82]}, 1'b1)
    // Entry on: new lead of 30 taken at start, after the load lag
    wr(pts_pkg::OFF_SW_BASE + 8'h04, 32'h0000_0300);
    go(5'h02);
    wait_run();
    `CHK((t_first - t0) inside {[770:810]}, 1'b1)
    // Repeat mode restarts on done, the button halts it
    go(5'h01);
    n = 0;
    while (n_done < 2 && n++ < 4000)
      @(posedge aclk);
    if (n > 4000)
      tmo();
    `CHK(n_done, 2)
    repeat (100) @(posedge aclk);
    `CHK(pins_out.sync_out, 1'b1)
    // External edge without the stop option leaves the cycle running
    press(3'h2);
    repeat (8) @(posedge aclk);
    `CHK(pins_out.sync_out, 1'b1)
    press(3'h4);
    repeat (8) @(posedge aclk);
    `CHK(pins_out.sync_out, 1'b0)
    rd_reg(pts_pkg::OFF_STATUS);
    `CHK(rd[0], 1'b0)
    // With the stop option set the external edge halts the cycle
    go(5'h11);
    repeat (100) @(posedge aclk);
    press(3'h2);
    repeat (8) @(posedge aclk);
    `CHK(pins_out.sync_out, 1'b0)
    // Paired unit answers done with a start
    pair_on <= 1'b1;
    go(5'h00);
    n = 0;
    while (n_done < 2 && n++ < 6000)
      @(posedge aclk);
    if (n > 6000)
      tmo();
    pair_on <= 1'b0;
    wait_run();
    `CHK(n_done, 2)
    summarize();
  end
endmodule
`default_nettype wire
